//--- verilog/diag_monitor_register_map.sv
// diagnostic monitor register map: limits, live readings, status, flags over ahb-lite
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
module diag_monitor_register_map
  import diag_monitor_pkg::*;
#(
  parameter int RESPONSE_LIMIT_CYCLES = RESPONSE_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // ahb-lite slave
  input wire ahb_req_t ahb_req_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // measurement engine
  input wire meas_vec_t meas_i,
  input wire logic [NUM_CH-1:0] meas_valid_i,
  // module pins
  input wire logic tx_disable_pin_i,
  input wire logic tx_fault_i,
  input wire logic rx_los_i,
  output logic tx_disable_o
);

  // shipped checksum over limits and calibration area
  localparam logic [7:0] CHECKSUM_VALUE = limits_checksum_calc();

  // bus phase state
  logic taken;
  logic [IDX_W-1:0] addr_idx;
  logic addr_mapped;
  logic wr_pend_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [31:0] rd_word_next;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  // block state
  logic soft_disable_reg;
  logic pin_disable_reg;
  logic fault_reg;
  logic los_reg;
  logic not_ready_reg;
  logic tx_disable_reg;
  logic [NUM_CH-1:0] seen_reg;
  logic [DATA_W-1:0] live_reg [NUM_CH];
  range_flags_t ch_flags [NUM_CH];

  // flag bytes
  logic [7:0] alarm_a;
  logic [7:0] alarm_b;
  logic [7:0] warn_a;
  logic [7:0] warn_b;
  logic [7:0] status_byte;
  logic soft_view;

  // address phase decode
  assign taken = ahb_req_i.hsel && ahb_req_i.htrans == HTRANS_NONSEQ && hready_i;
  assign addr_idx = ahb_req_i.haddr[IDX_W+1:2];
  assign addr_mapped = ahb_req_i.haddr[31:IDX_W+2] == '0;

  // write data phase tracking
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= '0;
    end
    else
    begin
      wr_pend_reg <= taken && ahb_req_i.hwrite && addr_mapped;
      if (taken)
        wr_idx_reg <= addr_idx;
    end
  end

  // zero wait state answer, always okay
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= HRESP_OKAY;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= HRESP_OKAY;
    end
  end

  // soft disable bit, only writable field of the map
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      soft_disable_reg <= RST_SOFT_DISABLE;
    else if (wr_pend_reg && wr_idx_reg == IDX_STATUS_AND_SOFT_CONTROL)
      soft_disable_reg <= hwdata_i[STAT_SOFT_DISABLE_BIT];
  end

  // pin mirrors, sampled every cycle
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pin_disable_reg <= 1'b0;
      fault_reg <= 1'b0;
      los_reg <= 1'b0;
    end
    else
    begin
      pin_disable_reg <= tx_disable_pin_i;
      fault_reg <= tx_fault_i;
      los_reg <= rx_los_i;
    end
  end

  // transmitter disable output, pin or soft bit
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      tx_disable_reg <= 1'b1;
    else
      tx_disable_reg <= tx_disable_pin_i | soft_disable_reg;
  end

  // live readings captured on each update strobe
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
      localparam limit_set_t CH_LIMITS = '{
        hi_alarm: LIMIT_DEFAULT[4*g],
        lo_alarm: LIMIT_DEFAULT[4*g+1],
        hi_warn: LIMIT_DEFAULT[4*g+2],
        lo_warn: LIMIT_DEFAULT[4*g+3]
      };

      // holding register for the reading
      always_ff @(posedge clk_i)
      begin
        if (!nrst_i)
          live_reg[g] <= RST_LIVE;
        else if (meas_valid_i[g])
          live_reg[g] <= meas_i[g];
      end

      // comparator, signed for temperature only
      limit_check #(
        .IS_SIGNED(g == CH_TEMP)
      ) u_check (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .update_i(meas_valid_i[g]),
        .value_i(meas_i[g]),
        .limits_i(CH_LIMITS),
        .flags_o(ch_flags[g])
      );
    end
  endgenerate

  // ready once every channel has one valid reading
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      seen_reg <= '0;
      not_ready_reg <= RST_NOT_READY;
    end
    else
    begin
      seen_reg <= seen_reg | meas_valid_i;
      not_ready_reg <= ~&seen_reg;
    end
  end

  // flag byte assembly
  assign alarm_a = {ch_flags[CH_TEMP].hi_alarm, ch_flags[CH_TEMP].lo_alarm,
                    ch_flags[CH_SUPPLY].hi_alarm, ch_flags[CH_SUPPLY].lo_alarm,
                    ch_flags[CH_BIAS].hi_alarm, ch_flags[CH_BIAS].lo_alarm,
                    ch_flags[CH_TXPOWER].hi_alarm, ch_flags[CH_TXPOWER].lo_alarm};
  assign alarm_b = {ch_flags[CH_RXPOWER].hi_alarm, ch_flags[CH_RXPOWER].lo_alarm,
                    6'b00_0000};
  assign warn_a = {ch_flags[CH_TEMP].hi_warn, ch_flags[CH_TEMP].lo_warn,
                   ch_flags[CH_SUPPLY].hi_warn, ch_flags[CH_SUPPLY].lo_warn,
                   ch_flags[CH_BIAS].hi_warn, ch_flags[CH_BIAS].lo_warn,
                   ch_flags[CH_TXPOWER].hi_warn, ch_flags[CH_TXPOWER].lo_warn};
  assign warn_b = {ch_flags[CH_RXPOWER].hi_warn, ch_flags[CH_RXPOWER].lo_warn,
                   6'b00_0000};

  // soft bit seen by a read right behind its write
  assign soft_view = (wr_pend_reg && wr_idx_reg == IDX_STATUS_AND_SOFT_CONTROL) ?
                     hwdata_i[STAT_SOFT_DISABLE_BIT] : soft_disable_reg;

  // status byte, reserved bits zero
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[STAT_PIN_DISABLE_BIT] = pin_disable_reg;
    status_byte[STAT_SOFT_DISABLE_BIT] = soft_view;
    status_byte[STAT_FAULT_BIT] = fault_reg;
    status_byte[STAT_LOS_BIT] = los_reg;
    status_byte[STAT_NOT_READY_BIT] = not_ready_reg;
  end

  // read mux: even index gives the whole value, odd index its low byte
  always_comb
  begin
    logic [DATA_W-1:0] sel;
    logic [IDX_W-1:0] live_off;
    sel = '0;
    live_off = addr_idx - IDX_LIVE_TEMPERATURE;
    rd_word_next = 32'h0000_0000;
    if (!addr_mapped)
      rd_word_next = 32'h0000_0000;
    else if (addr_idx <= IDX_LIMITS_LAST)
    begin
      sel = LIMIT_DEFAULT[addr_idx[5:1]];
      rd_word_next = addr_idx[0] ? {24'h00_0000, sel[7:0]} : {16'h0000, sel};
    end
    else if (addr_idx >= IDX_CAL_FIRST && addr_idx <= IDX_CAL_LAST)
      rd_word_next = {24'h00_0000, cal_byte(int'(addr_idx))};
    else if (addr_idx == IDX_LIMITS_CHECKSUM)
      rd_word_next = {24'h00_0000, CHECKSUM_VALUE};
    else if (addr_idx >= IDX_LIVE_TEMPERATURE && addr_idx <= IDX_LIVE_LAST)
    begin
      sel = live_reg[live_off[3:1]];
      rd_word_next = live_off[0] ? {24'h00_0000, sel[7:0]} : {16'h0000, sel};
    end
    else
    begin
      case (addr_idx)
        IDX_STATUS_AND_SOFT_CONTROL: rd_word_next = {24'h00_0000, status_byte};
        IDX_ALARM_FLAGS_A: rd_word_next = {24'h00_0000, alarm_a};
        IDX_ALARM_FLAGS_B: rd_word_next = {24'h00_0000, alarm_b};
        IDX_WARNING_FLAGS_A: rd_word_next = {24'h00_0000, warn_a};
        IDX_WARNING_FLAGS_B: rd_word_next = {24'h00_0000, warn_b};
        default: rd_word_next = 32'h0000_0000;
      endcase
    end
  end

  // read data registered at the address phase edge
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      hrdata_reg <= 32'h0000_0000;
    else if (taken && !ahb_req_i.hwrite)
      hrdata_reg <= rd_word_next;
  end

  // outputs straight from flip-flops
  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign tx_disable_o = tx_disable_reg;

endmodule

//--- verilog/diag_monitor_pkg.sv
// package: register indices, field positions, defaults and carrier types of the monitor map
package diag_monitor_pkg;

  // geometry
  localparam int NUM_CH = 5;
  localparam int LIMIT_COUNT = 20;
  localparam int IDX_W = 7;
  localparam int DATA_W = 16;

  // channel order
  localparam int CH_TEMP = 0;
  localparam int CH_SUPPLY = 1;
  localparam int CH_BIAS = 2;
  localparam int CH_TXPOWER = 3;
  localparam int CH_RXPOWER = 4;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TEMP_HIGH_ALARM_LIMIT = 7'h00;
  localparam logic [IDX_W-1:0] IDX_TEMP_LOW_ALARM_LIMIT = 7'h02;
  localparam logic [IDX_W-1:0] IDX_TEMP_HIGH_WARNING_LIMIT = 7'h04;
  localparam logic [IDX_W-1:0] IDX_TEMP_LOW_WARNING_LIMIT = 7'h06;
  localparam logic [IDX_W-1:0] IDX_SUPPLY_HIGH_ALARM_LIMIT = 7'h08;
  localparam logic [IDX_W-1:0] IDX_SUPPLY_LOW_ALARM_LIMIT = 7'h0a;
  localparam logic [IDX_W-1:0] IDX_SUPPLY_HIGH_WARNING_LIMIT = 7'h0c;
  localparam logic [IDX_W-1:0] IDX_SUPPLY_LOW_WARNING_LIMIT = 7'h0e;
  localparam logic [IDX_W-1:0] IDX_BIAS_HIGH_ALARM_LIMIT = 7'h10;
  localparam logic [IDX_W-1:0] IDX_BIAS_LOW_ALARM_LIMIT = 7'h12;
  localparam logic [IDX_W-1:0] IDX_BIAS_HIGH_WARNING_LIMIT = 7'h14;
  localparam logic [IDX_W-1:0] IDX_BIAS_LOW_WARNING_LIMIT = 7'h16;
  localparam logic [IDX_W-1:0] IDX_TXPOWER_HIGH_ALARM_LIMIT = 7'h18;
  localparam logic [IDX_W-1:0] IDX_TXPOWER_LOW_ALARM_LIMIT = 7'h1a;
  localparam logic [IDX_W-1:0] IDX_TXPOWER_HIGH_WARNING_LIMIT = 7'h1c;
  localparam logic [IDX_W-1:0] IDX_TXPOWER_LOW_WARNING_LIMIT = 7'h1e;
  localparam logic [IDX_W-1:0] IDX_RXPOWER_HIGH_ALARM_LIMIT = 7'h20;
  localparam logic [IDX_W-1:0] IDX_RXPOWER_LOW_ALARM_LIMIT = 7'h22;
  localparam logic [IDX_W-1:0] IDX_RXPOWER_HIGH_WARNING_LIMIT = 7'h24;
  localparam logic [IDX_W-1:0] IDX_RXPOWER_LOW_WARNING_LIMIT = 7'h26;
  localparam logic [IDX_W-1:0] IDX_LIMITS_LAST = 7'h27;
  localparam logic [IDX_W-1:0] IDX_CAL_FIRST = 7'h38;
  localparam logic [IDX_W-1:0] IDX_CAL_LAST = 7'h5e;
  localparam logic [IDX_W-1:0] IDX_LIMITS_CHECKSUM = 7'h5f;
  localparam logic [IDX_W-1:0] IDX_LIVE_TEMPERATURE = 7'h60;
  localparam logic [IDX_W-1:0] IDX_LIVE_SUPPLY = 7'h62;
  localparam logic [IDX_W-1:0] IDX_LIVE_BIAS = 7'h64;
  localparam logic [IDX_W-1:0] IDX_LIVE_TXPOWER = 7'h66;
  localparam logic [IDX_W-1:0] IDX_LIVE_RXPOWER = 7'h68;
  localparam logic [IDX_W-1:0] IDX_LIVE_LAST = 7'h69;
  localparam logic [IDX_W-1:0] IDX_STATUS_AND_SOFT_CONTROL = 7'h6e;
  localparam logic [IDX_W-1:0] IDX_ALARM_FLAGS_A = 7'h70;
  localparam logic [IDX_W-1:0] IDX_ALARM_FLAGS_B = 7'h71;
  localparam logic [IDX_W-1:0] IDX_WARNING_FLAGS_A = 7'h74;
  localparam logic [IDX_W-1:0] IDX_WARNING_FLAGS_B = 7'h75;

  // status byte field positions
  localparam int STAT_PIN_DISABLE_BIT = 7;
  localparam int STAT_SOFT_DISABLE_BIT = 6;
  localparam int STAT_FAULT_BIT = 2;
  localparam int STAT_LOS_BIT = 1;
  localparam int STAT_NOT_READY_BIT = 0;

  // reset values
  localparam logic RST_SOFT_DISABLE = 1'b0;
  localparam logic RST_NOT_READY = 1'b1;
  localparam logic [DATA_W-1:0] RST_LIVE = 16'h0000;

  // calibration defaults: unity slopes (msb 0x01) at every fourth byte from 76 to 88
  localparam int IDX_CAL_SLOPE_FIRST = 76;
  localparam int IDX_CAL_SLOPE_LAST = 88;
  localparam int CAL_SLOPE_STRIDE = 4;
  localparam logic [7:0] CAL_UNITY_MSB = 8'h01;

  // bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

  // soft command response time and its cycle count at 20 MHz
  localparam int RESPONSE_TIME_MS = 100;
  localparam int CLK_HZ = 20000000;
  localparam int RESPONSE_CYCLES = RESPONSE_TIME_MS * (CLK_HZ / 1000);

  // limits: per channel high alarm, low alarm, high warning, low warning
  localparam logic [DATA_W-1:0] LIMIT_DEFAULT [LIMIT_COUNT] = '{
    16'h4b00, 16'hfb00, 16'h4600, 16'h0000,
    16'h8ca0, 16'h7530, 16'h88b8, 16'h7918,
    16'h4e20, 16'h03e8, 16'h4650, 16'h07d0,
    16'h2710, 16'h0400, 16'h1f40, 16'h0600,
    16'h2710, 16'h0064, 16'h1f40, 16'h00c8
  };

  // carrier types
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
  } ahb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] hi_alarm;
    logic [DATA_W-1:0] lo_alarm;
    logic [DATA_W-1:0] hi_warn;
    logic [DATA_W-1:0] lo_warn;
  } limit_set_t;

  typedef struct packed {
    logic hi_alarm;
    logic lo_alarm;
    logic hi_warn;
    logic lo_warn;
  } range_flags_t;

  typedef logic [NUM_CH-1:0][DATA_W-1:0] meas_vec_t;

  // default byte of the unused calibration area
  function automatic logic [7:0] cal_byte(input int idx);
    cal_byte = 8'h00;
    if (idx >= IDX_CAL_SLOPE_FIRST && idx <= IDX_CAL_SLOPE_LAST &&
        ((idx - IDX_CAL_SLOPE_FIRST) % CAL_SLOPE_STRIDE) == 0)
      cal_byte = CAL_UNITY_MSB;
  endfunction

  // low byte of the sum over limit and calibration bytes
  function automatic logic [7:0] limits_checksum_calc();
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < LIMIT_COUNT; i++)
      sum = sum + LIMIT_DEFAULT[i][15:8] + LIMIT_DEFAULT[i][7:0];
    for (int j = int'(IDX_CAL_FIRST); j <= int'(IDX_CAL_LAST); j++)
      sum = sum + cal_byte(j);
    return sum;
  endfunction

endpackage

//--- verilog/limit_check.sv
// threshold comparator: four range flags re-evaluated at each measurement update
`timescale 1ns/10ps
module limit_check
  import diag_monitor_pkg::*;
#(
  parameter bit IS_SIGNED = 1'b0
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // measurement
  input wire logic update_i,
  input wire logic [DATA_W-1:0] value_i,
  input wire limit_set_t limits_i,
  // result
  output range_flags_t flags_o
);

  // strict compare, signed for the temperature channel
  function automatic logic above(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    if (IS_SIGNED)
      above = $signed(a) > $signed(b);
    else
      above = a > b;
  endfunction

  // flags follow the latest sample, not sticky
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      flags_o <= '0;
    else if (update_i)
    begin
      flags_o.hi_alarm <= above(value_i, limits_i.hi_alarm);
      flags_o.lo_alarm <= above(limits_i.lo_alarm, value_i);
      flags_o.hi_warn <= above(value_i, limits_i.hi_warn);
      flags_o.lo_warn <= above(limits_i.lo_warn, value_i);
    end
  end

endmodule

//--- dv/diag_monitor_chk.sv
// checker: read-back, pin mirrors and transmitter disable of the monitor map
`timescale 1ns/10ps
module diag_monitor_chk
  import diag_monitor_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // bus
  input wire ahb_req_t ahb_req_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  // readings and pins
  input wire meas_vec_t meas_i,
  input wire logic [NUM_CH-1:0] meas_valid_i,
  input wire logic tx_disable_pin_i,
  input wire logic tx_fault_i,
  input wire logic rx_los_i,
  input wire logic tx_disable_o
);
  logic [IDX_W-1:0] idx;
  logic rdt, wr_pend, soft_m, val_chk, stat_chk, soft_exp, all_seen, dis_req;
  logic [15:0] val_exp;
  logic [NUM_CH-1:0] seen;
  meas_vec_t live_m;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // read taken at an address edge
  assign idx = ahb_req_i.haddr[8:2];
  assign rdt = ahb_req_i.hsel && ahb_req_i.htrans == HTRANS_NONSEQ && hready_i
    && !ahb_req_i.hwrite && ahb_req_i.haddr[31:9] == '0;
  assign all_seen = &seen;
  assign dis_req = tx_disable_pin_i | soft_m;

  // soft disable shadow
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wr_pend <= 1'b0;
      soft_m <= RST_SOFT_DISABLE;
    end
    else
    begin
      wr_pend <= ahb_req_i.hsel && ahb_req_i.htrans == HTRANS_NONSEQ && hready_i
        && ahb_req_i.hwrite && ahb_req_i.haddr == {23'h0, IDX_STATUS_AND_SOFT_CONTROL, 2'b00};
      if (wr_pend && hready_i)
        soft_m <= hwdata_i[STAT_SOFT_DISABLE_BIT];
    end
  end

  // live reading shadow and first-update tracking
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      live_m <= '0;
      seen <= '0;
    end
    else
      for (int g = 0; g < NUM_CH; g++)
        if (meas_valid_i[g])
        begin
          live_m[g] <= meas_i[g];
          seen[g] <= 1'b1;
        end
  end

  // expected read data, fixed at the address edge
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      val_chk <= 1'b0;
      stat_chk <= 1'b0;
      val_exp <= '0;
      soft_exp <= 1'b0;
    end
    else
    begin
      val_chk <= rdt && !idx[0] && (idx <= IDX_LIMITS_LAST
        || (idx >= IDX_LIVE_TEMPERATURE && idx <= IDX_LIVE_LAST));
      stat_chk <= rdt && idx == IDX_STATUS_AND_SOFT_CONTROL;
      val_exp <= idx <= IDX_LIMITS_LAST ? LIMIT_DEFAULT[idx[5:1]] : live_m[idx[3:1]];
      soft_exp <= (wr_pend && hready_i) ? hwdata_i[STAT_SOFT_DISABLE_BIT] : soft_m;
    end
  end

  // a pin held steady reads back in its status bit
  property mirror_p(logic pin, int pos);
    stat_chk && $past(pin) == $past(pin, 2) |-> hrdata_o[pos] == $past(pin);
  endproperty

  AST_VALUE_READ: assert property (val_chk |-> hrdata_o[15:0] == val_exp)
    else $error("limit or live value read wrong");
  AST_SOFT_READ: assert property (stat_chk |-> hrdata_o[6] == soft_exp)
    else $error("soft disable bit read wrong");
  AST_PIN_STATE: assert property (mirror_p(tx_disable_pin_i, STAT_PIN_DISABLE_BIT))
    else $error("disable pin state read wrong");
  AST_FAULT_STATE: assert property (mirror_p(tx_fault_i, STAT_FAULT_BIT))
    else $error("fault state read wrong");
  AST_LOS_STATE: assert property (mirror_p(rx_los_i, STAT_LOS_BIT))
    else $error("loss of signal state read wrong");
  AST_NOT_READY: assert property (stat_chk && !$past(all_seen) |-> hrdata_o[0])
    else $error("ready shown before all readings");
  AST_READY: assert property (stat_chk && $past(all_seen, 3) |-> !hrdata_o[0])
    else $error("ready not shown");
  AST_TXDIS_OR: assert property (1'b1 |=> tx_disable_o == $past(dis_req))
    else $error("transmitter disable not pin or soft");
  AST_PIN_RISE: assert property ($rose(tx_disable_pin_i) |=> tx_disable_o)
    else $error("disable pin did not disable");

  // main scenarios reached
  COV_SOFT: cover property (stat_chk && soft_exp);
  COV_LIVE: cover property (val_chk && hrdata_o[15]);
  COV_TXEN: cover property ($fell(tx_disable_o));
endmodule

bind diag_monitor_register_map diag_monitor_chk u_chk (
  .clk_i, .nrst_i, .ahb_req_i, .hready_i, .hwdata_i, .hrdata_o, .meas_i, .meas_valid_i,
  .tx_disable_pin_i, .tx_fault_i, .rx_los_i, .tx_disable_o
);

//--- dv/ahb_host_model.sv
// host controller model: single-word ahb-lite master for the monitor map
`timescale 1ns/10ps
module ahb_host_model
  import diag_monitor_pkg::*;
(
  // clock
  input wire logic clk_i,
  // bus
  output ahb_req_t ahb_req_o,
  output logic [31:0] hwdata_o,
  input wire logic [31:0] hrdata_i,
  input wire logic hready_i
);
  // idle bus at time zero
  initial
  begin
    ahb_req_o = '0;
    hwdata_o = 32'h0;
  end

  // one transfer, entered just after a rising edge; waits end only by the watchdog
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
    output logic [31:0] rd);
    ahb_req_o <= '{hsel: 1'b1, haddr: addr, htrans: HTRANS_NONSEQ, hwrite: wr, hsize: 3'b010};
    do @(posedge clk_i); while (hready_i !== 1'b1);
    ahb_req_o.htrans <= 2'b00;
    ahb_req_o.haddr <= ~addr;  // released lines show a changed pattern
    hwdata_o <= wr ? wd : ~hwdata_o;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
  endtask
endmodule

//--- dv/tb_diag_monitor_register_map.sv
// testbench: monitor map readings, flags, fixed area, soft disable and reset
`timescale 1ns/10ps
module tb_diag_monitor_register_map
  import diag_monitor_pkg::*;
;
  typedef struct packed {
    logic [2:0] ch;
    logic [15:0] val;
    logic [3:0] flags;  // high alarm, low alarm, high warning, low warning
  } row_t;
  localparam int NROWS = 10;
  localparam row_t ROWS [NROWS] = '{
    '{3'd0, 16'h4b01, 4'b1010}, '{3'd0, 16'h8000, 4'b0101}, '{3'd0, 16'h4b00, 4'b0010},
    '{3'd1, 16'h8ca1, 4'b1010}, '{3'd1, 16'h7917, 4'b0001}, '{3'd2, 16'h03e7, 4'b0101},
    '{3'd3, 16'h2000, 4'b0010}, '{3'd3, 16'h0400, 4'b0001}, '{3'd4, 16'h0063, 4'b0101},
    '{3'd4, 16'h8000, 4'b1010}
  };

  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  ahb_req_t req;
  logic [31:0] hwdata, hrdata, d, e;
  logic hready, hresp, txdis;
  meas_vec_t meas = '0;
  logic [NUM_CH-1:0] mvalid = '0;
  logic pin = 1'b0;
  logic fault = 1'b0;
  logic los = 1'b0;
  logic [7:0] sum;
  int fails = 0;
  int cmp_count = 0;
  int hp;

  diag_monitor_register_map #(.RESPONSE_LIMIT_CYCLES(16)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .ahb_req_i(req), .hready_i(hready), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .meas_i(meas),
    .meas_valid_i(mvalid), .tx_disable_pin_i(pin), .tx_fault_i(fault), .rx_los_i(los),
    .tx_disable_o(txdis)
  );
  ahb_host_model host (
    .clk_i(clk_i), .ahb_req_o(req), .hwdata_o(hwdata), .hrdata_i(hrdata), .hready_i(hready)
  );

  // clock and watchdog
  initial
    forever #25 clk_i = ~clk_i;
  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    $display("mismatch watchdog expected end seen hang");
    finish_test();
  end

  // comparisons and bus access
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic rd(input int idx, output logic [31:0] v);
    host.xfer(1'b0, 32'(idx * 4), 32'h0, v);
  endtask
  task automatic wr(input int idx, input logic [31:0] v);
    logic [31:0] x;
    host.xfer(1'b1, 32'(idx * 4), v, x);
  endtask
  task automatic stat(input logic [7:0] exp);
    logic [31:0] v;
    rd(IDX_STATUS_AND_SOFT_CONTROL, v);
    chk("status", {24'h0, exp}, v);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    stat(8'h01);
    chk_pin("tx disable", 1'b0, txdis);
    chk_pin("hresp", HRESP_OKAY, hresp);
    chk_pin("hready", 1'b1, hready);
    $display("test reset start done");
    // one reading per row, then its live value and flag pairs
    for (int r = 0; r < NROWS; r++)
    begin
      meas[ROWS[r].ch] <= ROWS[r].val;
      mvalid[ROWS[r].ch] <= 1'b1;
      @(posedge clk_i);
      mvalid <= '0;
      @(posedge clk_i);
      rd(IDX_LIVE_TEMPERATURE + 2 * ROWS[r].ch, d);
      chk("live", {16'h0, ROWS[r].val}, d);
      rd(IDX_LIVE_TEMPERATURE + 2 * ROWS[r].ch + 1, d);
      chk("live low", {24'h0, ROWS[r].val[7:0]}, d);
      hp = ROWS[r].ch == 4 ? 7 : 7 - 2 * ROWS[r].ch;
      for (int w = 0; w < 2; w++)
      begin
        rd(int'(w ? IDX_WARNING_FLAGS_A : IDX_ALARM_FLAGS_A) + int'(ROWS[r].ch == 4), d);
        chk("flags", {30'h0, ROWS[r].flags[3 - 2 * w -: 2]}, {30'h0, d[hp -: 2]});
        if (ROWS[r].ch == 4)
          chk("flag reserved", 32'h0, d & 32'hffff_ff3f);
      end
    end
    stat(8'h00);
    $display("test readings and flags done");
    // fixed area: limits, reserved gap, calibration defaults, checksum
    sum = 8'h00;
    for (int i = 0; i < 95; i++)
    begin
      if (i < 40)
        e = i[0] ? {24'h0, LIMIT_DEFAULT[i / 2][7:0]} : {16'h0, LIMIT_DEFAULT[i / 2]};
      else
        e = {31'h0, i >= 76 && i <= 88 && i % 4 == 0};
      sum = sum + ((i[0] || i >= 40) ? e[7:0] : e[15:8]);
      rd(i, d);
      chk("fixed byte", e, d);
    end
    rd(IDX_LIMITS_CHECKSUM, d);
    chk("checksum", {24'h0, sum}, d);
    wr(IDX_TEMP_HIGH_ALARM_LIMIT, 32'h0000_ffff);
    rd(IDX_TEMP_HIGH_ALARM_LIMIT, d);
    chk("read-only limit", {16'h0, LIMIT_DEFAULT[0]}, d);
    host.xfer(1'b0, 32'h0000_0400, 32'h0, d);
    chk("unmapped", 32'h0, d);
    $display("test fixed area done");
    // soft disable, pin mirrors and their combination
    wr(IDX_STATUS_AND_SOFT_CONTROL, 32'h0000_0040);
    stat(8'h40);
    chk_pin("tx disable soft", 1'b1, txdis);
    pin <= 1'b1;
    fault <= 1'b1;
    los <= 1'b1;
    wr(IDX_STATUS_AND_SOFT_CONTROL, 32'h0000_00bf);
    stat(8'h86);
    chk_pin("tx disable pin", 1'b1, txdis);
    pin <= 1'b0;
    fault <= 1'b0;
    los <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_pin("tx enabled", 1'b0, txdis);
    $display("test soft disable done");
    // reset in mid-run clears soft bit, readiness and readings
    wr(IDX_STATUS_AND_SOFT_CONTROL, 32'h0000_0040);
    nrst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk_pin("tx disable in reset", 1'b1, txdis);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    stat(8'h01);
    rd(IDX_LIVE_TEMPERATURE, d);
    chk("live after reset", 32'h0, d);
    $display("test reset done");
    finish_test();
  end
endmodule
